// ### assf_defines.vh
// Register offsets, field positions, reset values and timing counts for the serial status flag block
`ifndef ASSF_DEFINES_VH
`define ASSF_DEFINES_VH
// ==========================================================
// Register byte offsets
`define ASSF_CTRL_OFS 12'h000
`define ASSF_STAT_OFS 12'h004
`define ASSF_TXD_OFS 12'h008
`define ASSF_RXD_OFS 12'h00C
// ==========================================================
// Control fields
`define ASSF_CTRL_TXEN 0
`define ASSF_CTRL_TXEIE 1
`define ASSF_CTRL_TXCIE 2
`define ASSF_CTRL_RXFIE 3
`define ASSF_CTRL_IDLIE 4
`define ASSF_CTRL_RST 32'h00000000
// ==========================================================
// Status fields
`define ASSF_STAT_TXE 0
`define ASSF_STAT_TXC 1
`define ASSF_STAT_RXF 2
`define ASSF_STAT_OVR 3
`define ASSF_STAT_NSE 4
`define ASSF_STAT_FRM 5
`define ASSF_STAT_IDL 6
`define ASSF_STAT_TXACT 7
// ==========================================================
// Timing
`define ASSF_BIT_CYCLES 16
`define ASSF_CHAR_BITS 10
`endif

// ### assf_tx_shifter.v
// Transmit shifter for the serial status flag block
`include "assf_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module assf_tx_shifter #(
    parameter BIT_CYCLES = `ASSF_BIT_CYCLES
)(
    input wire clk, // Clock
    input wire rst, // Async reset, high
    input wire ce, // Clock enable
    input wire start, // Load and start a character
    input wire [7:0] data, // Character to send
    output reg busy, // Character in progress
    output reg done, // One-cycle pulse at stop bit end
    output reg txd // Serial output
);
    reg [8:0] shreg;
    reg [3:0] bitcnt;
    reg [15:0] divcnt;
    // ==========================================================
    // Shift out start, eight data bits and stop, LSB first
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0; // RQ6
            done <= 1'b0;
            txd <= 1'b1;
            shreg <= 9'h1FF;
            bitcnt <= 4'h0;
            divcnt <= 16'h0000;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (!busy)
            begin
                if (start)
                begin
                    busy <= 1'b1;
                    txd <= 1'b0;
                    shreg <= {1'b1, data};
                    bitcnt <= 4'h0;
                    divcnt <= 16'h0000;
                end
            end
            else if (divcnt == BIT_CYCLES - 1)
            begin
                divcnt <= 16'h0000;
                if (bitcnt == 4'h9)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    txd <= shreg[0];
                    shreg <= {1'b1, shreg[8:1]};
                    bitcnt <= bitcnt + 4'h1;
                end
            end
            else
                divcnt <= divcnt + 16'h0001;
        end
    end
endmodule // assf_tx_shifter
`default_nettype wire

// ### assf_status.v
// Status flags, interrupt request and APB registers of the async serial unit
// Contract
// (RQ1) Enabling the transmitter sets transmit-empty and transmit-complete flags.
// (RQ2) Transmit-empty means queue has room; irq while flag and mask set.
// (RQ3) Transmit-complete means queue drained; irq while flag and mask set. txc sets at every sh_done, even with a character still pending.
// (RQ4) Hardware sets flags, software clears them through its normal accesses.
// (RQ5) Clearing enable finishes the character being shifted first.
// (RQ6) Only reset aborts the transmitter immediately.
// (RQ7) Disable while idle returns pin to port use, on bit clock.
// (RQ8) Disable mid-character finishes it, drops queue, then releases pin.
// (RQ9) After last character following disable, both transmit flags set.
// (RQ10) Five receive flags readable; full, overrun, idle may interrupt.
// (RQ11) Receive-full sets when a character moves into the receive register.
// (RQ12) On overrun keep old character, drop new, set overrun not full.
// (RQ13) Noise and framing flags describe held character, never interrupt.
// (RQ14) Line idle after one full character time at logic 1.
// (RQ15) Idle flag sets only on busy-to-idle transition.
// (RQ16) All enabled sources combine onto one interrupt line.
`include "assf_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module assf_status #(
    parameter BIT_CYCLES = `ASSF_BIT_CYCLES,
    parameter CHAR_BITS = `ASSF_CHAR_BITS
)(
    input wire clk, // Clock, 250 MHz
    input wire rst, // Async reset, high
    input wire ce, // Clock enable
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output wire pslverr, // APB error
    input wire rx_char_valid, // Receive shifter has a character, one-cycle pulse
    input wire [7:0] rx_char_data, // Received character
    input wire rx_char_noise, // Noise seen on that character
    input wire rx_char_frame, // Stop bit was low
    input wire rxd, // Receive line level
    output wire txd_out, // Transmit pin value
    output wire txd_oe, // High while the unit owns the pin
    output wire irq // Combined interrupt request
);
    // ==========================================================
    // Bus decode
    wire acc = psel & penable & ce;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire hit_ctrl = (paddr == `ASSF_CTRL_OFS);
    wire hit_stat = (paddr == `ASSF_STAT_OFS);
    wire hit_txd = (paddr == `ASSF_TXD_OFS);
    wire hit_rxd = (paddr == `ASSF_RXD_OFS);
    wire mapped = hit_ctrl | hit_stat | hit_txd | hit_rxd;
    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    reg [4:0] ctrl;
    reg txe, txc, rxf, ovr, nse, frm, idl;
    reg [7:0] tx_hold;
    reg tx_pend;
    reg [7:0] rx_data;
    reg stat_seen;
    reg pin_own;
    wire tx_en = ctrl[`ASSF_CTRL_TXEN];
    wire sh_busy, sh_done, sh_txd;
    wire sh_start = tx_en & tx_pend & ~sh_busy;

    // ==========================================================
    // Control register
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl <= 5'h00;
        else if (wr && hit_ctrl)
            ctrl <= pwdata[4:0];
    end

    // Status read marks the first step of each clearing sequence
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            stat_seen <= 1'b0;
        else if (rd && hit_stat)
            stat_seen <= 1'b1;
        else if (acc && (hit_txd || hit_rxd))
            stat_seen <= 1'b0;
    end

    // ==========================================================
    // Transmit queue and flags
    wire en_rise = wr & hit_ctrl & pwdata[`ASSF_CTRL_TXEN] & ~tx_en;
    wire txd_wr = wr & hit_txd;
    wire clr_tx = txd_wr & stat_seen; // RQ4
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Reset kills any character at once RQ6
            txe <= 1'b0;
            txc <= 1'b0;
            tx_pend <= 1'b0;
            tx_hold <= 8'h00;
        end
        else if (ce)
        begin
            if (txd_wr)
            begin
                tx_hold <= pwdata[7:0];
                tx_pend <= 1'b1;
            end
            else if (sh_start)
                tx_pend <= 1'b0;
            else if (!tx_en && !sh_busy)
                tx_pend <= 1'b0; // RQ8
            // Set wins over clear for both flags
            if (en_rise || sh_start || sh_done)
                txe <= 1'b1; // RQ1 RQ2 RQ9
            else if (clr_tx)
                txe <= 1'b0;
            if (en_rise || sh_done)
                txc <= 1'b1; // RQ1 RQ3 RQ9
            else if (clr_tx)
                txc <= 1'b0;
        end
    end

    // ==========================================================
    // Free-running bit-rate tick; the pin is handed back on it so the
    // port sees the switch at a bit boundary, never in mid-bit
    reg [15:0] bit_div;
    wire bit_tick = (bit_div == BIT_CYCLES - 1);
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            bit_div <= 16'h0000;
        else if (ce)
        begin
            if (bit_tick)
                bit_div <= 16'h0000;
            else
                bit_div <= bit_div + 16'h0001;
        end
    end

    // ==========================================================
    // Pin ownership follows the shifter so disable never truncates a character
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            pin_own <= 1'b0;
        else if (ce)
        begin
            if (tx_en)
                pin_own <= 1'b1;
            else if (!sh_busy && !tx_pend && bit_tick)
                pin_own <= 1'b0; // RQ5 RQ7 RQ8
        end
    end
    assign txd_oe = pin_own;
    assign txd_out = pin_own ? sh_txd : 1'b1;

    assf_tx_shifter #(.BIT_CYCLES(BIT_CYCLES)) u_shift (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(sh_start),
        .data(tx_hold),
        .busy(sh_busy),
        .done(sh_done),
        .txd(sh_txd)
    );

    // ==========================================================
    // Receive register and flags
    wire rxd_rd = rd & hit_rxd;
    wire clr_rx = rxd_rd & stat_seen; // RQ4
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_data <= 8'h00;
            rxf <= 1'b0;
            ovr <= 1'b0;
            nse <= 1'b0;
            frm <= 1'b0;
        end
        else if (ce)
        begin
            if (rx_char_valid && rxf && !clr_rx)
                ovr <= 1'b1; // RQ12
            else if (clr_rx)
                ovr <= 1'b0;
            if (rx_char_valid && (!rxf || clr_rx))
            begin
                // New character and its quality flags move in together RQ11 RQ13
                rx_data <= rx_char_data;
                rxf <= 1'b1;
                nse <= rx_char_noise;
                frm <= rx_char_frame;
            end
            else if (clr_rx)
            begin
                rxf <= 1'b0;
                nse <= 1'b0;
                frm <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Idle line detection over one character time
    localparam IDLE_CYCLES = BIT_CYCLES * CHAR_BITS;
    reg [19:0] idle_cnt;
    reg line_busy;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            idle_cnt <= 20'h00000;
            line_busy <= 1'b0;
            idl <= 1'b0;
        end
        else if (ce)
        begin
            if (!rxd)
            begin
                idle_cnt <= 20'h00000;
                line_busy <= 1'b1;
            end
            else if (idle_cnt != IDLE_CYCLES - 1)
                idle_cnt <= idle_cnt + 20'h00001; // RQ14
            if (rxd && line_busy && idle_cnt == IDLE_CYCLES - 1)
            begin
                line_busy <= 1'b0;
                idl <= 1'b1; // RQ15
            end
            else if (clr_rx)
                idl <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt combine; noise and framing stay out RQ10 RQ13
    assign irq = (txe & ctrl[`ASSF_CTRL_TXEIE]) // RQ2
        | (txc & ctrl[`ASSF_CTRL_TXCIE]) // RQ3
        | ((rxf | ovr) & ctrl[`ASSF_CTRL_RXFIE])
        | (idl & ctrl[`ASSF_CTRL_IDLIE]); // RQ16

    // ==========================================================
    // Read data, registered in the setup cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (ce && psel && !penable && !pwrite)
        begin
            if (paddr == `ASSF_CTRL_OFS)
                prdata <= {27'h0000000, ctrl};
            else if (paddr == `ASSF_STAT_OFS)
                prdata <= {24'h000000, sh_busy, idl, frm, nse, ovr, rxf, txc, txe}; // RQ10
            else if (paddr == `ASSF_RXD_OFS)
                prdata <= {24'h000000, rx_data};
            else
                prdata <= 32'h00000000;
        end
    end
endmodule // assf_status
`default_nettype wire

// ### assf_status_properties.sv
// Port-level assertions for the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module assf_status_properties #(
    parameter BIT_CYCLES = 4
)(
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic pready, // APB ready
    input wire logic [31:0] prdata, // APB read data
    input wire logic pslverr, // APB error
    input wire logic txd_out, // Serial output
    input wire logic txd_oe, // Pin owned
    input wire logic irq // Interrupt request
);
    // ==========================================
    // Helpers: access phase, decode, low run length of the serial line
    wire acc = psel && penable;
    wire mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C;
    logic [15:0] lo_run;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            lo_run <= 16'h0000;
        else
            lo_run <= txd_out ? 16'h0000 : lo_run + 16'h0001;
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_in_access: assert property (acc |-> pready) else $error("ready missing");
    a_error_on_unmapped: assert property (acc |-> pslverr == !mapped) else $error("bad error");
    a_read_data_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved");
    a_pin_idle_high: assert property (!txd_oe |-> txd_out) else $error("pin low unowned");
    a_whole_bit_times: assert property ($rose(txd_out) |-> lo_run % BIT_CYCLES == 0)
        else $error("partial bit");
    a_frame_keeps_pin: assert property (txd_oe && !txd_out |=> txd_oe)
        else $error("pin dropped mid frame");
    a_irq_quiet_reset: assert property ($fell(rst) |-> !irq) else $error("irq at reset");
    a_start_bit_len: assert property ($fell(txd_out) |-> (!txd_out) [*4])
        else $error("short low bit");
    a_pin_taken_high: assert property ($rose(txd_oe) |-> txd_out) else $error("glitch");
    cover property ($rose(txd_out));
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule // assf_status_properties
`default_nettype wire

// ### assf_remote.sv
// Far-end serial device: sends characters and captures what the block sends
`timescale 1ns/1ps
`default_nettype none
module assf_remote #(
    parameter BIT_CYCLES = 4,
    parameter CHAR_BITS = 10
)(
    input wire logic clk, // Clock
    input wire logic txd_out, // Line from the block
    input wire logic txd_oe, // Block owns the line
    output logic rx_char_valid, // Character pulse
    output logic [7:0] rx_char_data, // Character
    output logic rx_char_noise, // Noise seen
    output logic rx_char_frame, // Stop bit low
    output logic rxd, // Line to the block
    output logic [7:0] got, // Last captured character
    output int got_n // Captured count
);
    int i;
    // ==========================================
    // Frame one character onto rxd, then pulse it; data lines are scrambled outside the pulse
    task send(input logic [7:0] b, input logic n, input logic f);
        int k;
        for (k = 0; k < CHAR_BITS; k++)
        begin
            rxd <= (k == 0) ? 1'b0 : (k <= 8) ? b[k-1] : !f;
            repeat (BIT_CYCLES) @(posedge clk);
        end
        rx_char_valid <= 1'b1;
        {rx_char_data, rx_char_noise, rx_char_frame} <= {b, n, f};
        rxd <= 1'b1;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        {rx_char_data, rx_char_noise, rx_char_frame} <= ~{b, n, f};
    endtask
    // ==========================================
    // Capture the block's characters at mid-bit, LSB first
    initial
    begin
        {rx_char_valid, rx_char_data, rx_char_noise, rx_char_frame, rxd} = 12'h001;
        got_n = 0;
        forever
        begin
            @(posedge clk);
            if (txd_oe && txd_out === 1'b0)
            begin
                repeat (BIT_CYCLES / 2) @(posedge clk);
                for (i = 0; i < 8; i++)
                begin
                    repeat (BIT_CYCLES) @(posedge clk);
                    got[i] = txd_out;
                end
                repeat (BIT_CYCLES) @(posedge clk);
                got_n++;
            end
        end
    end
endmodule // assf_remote
`default_nettype wire

// ### assf_status_tb.sv
// Self-checking testbench of the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module assf_status_tb;
    // ==========================================
    // Stimulus, wires and instances; bit time cut to four clocks
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] rd;
    logic err;
    int got_n;
    int n0;
    int n_fail = 0;
    int checks = 0;
    wire pready, pslverr, txd_out, txd_oe, irq, rx_char_valid, rx_char_noise, rx_char_frame, rxd;
    wire [31:0] prdata;
    wire [7:0] rx_char_data, got;
    always #2 clk = ~clk;
    assf_status #(.BIT_CYCLES(4)) i_dut (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .rx_char_valid, .rx_char_data, .rx_char_noise,
        .rx_char_frame, .rxd, .txd_out, .txd_oe, .irq);
    assf_remote #(.BIT_CYCLES(4)) i_far (.clk, .txd_out, .txd_oe, .rx_char_valid, .rx_char_data,
        .rx_char_noise, .rx_char_frame, .rxd, .got, .got_n);
    // ==========================================
    // Compare, finish, bus cycle, status poll
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Request held until ready is seen at an edge, then released
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            if (++n > 20)
            begin
                n_fail++;
                stop_test;
            end
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        // One idle edge, so a following call never reassigns psel in the same step
        @(posedge clk);
    endtask
    task wait_stat(input int b);
        int n;
        n = 0;
        rd = 32'h00000000;
        while (rd[b] !== 1'b1)
        begin
            if (++n > 300)
            begin
                n_fail++;
                stop_test;
            end
            apb(1'b0, 12'h004, 32'h00000000);
        end
    endtask
    // ==========================================
    // Scenarios
    task t_bus;
        ce <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000001F);
        ce <= 1'b1;
        apb(1'b0, 12'h000, 32'h00000000);
        check("frozen ctrl", rd, 32'h00000000);
        apb(1'b0, 12'h010, 32'h00000000);
        check("unmapped error", err, 1'b1);
        apb(1'b1, 12'h004, 32'h000000FF);
        apb(1'b0, 12'h004, 32'h00000000);
        check("status not writable", rd[7:0], 8'h00);
        check("mapped no error", err, 1'b0);
    endtask
    task t_tx;
        apb(1'b1, 12'h000, 32'h00000003);
        apb(1'b0, 12'h004, 32'h00000000);
        check("flags on enable", rd[1:0], 2'h3);
        check("empty irq", irq, 1'b1);
        apb(1'b1, 12'h008, 32'h000000A5);
        apb(1'b0, 12'h004, 32'h00000000);
        check("flags while sending", rd[1:0], 2'h1);
        apb(1'b1, 12'h000, 32'h00000005);
        check("empty masked", irq, 1'b0);
        wait_stat(1);
        check("complete irq", irq, 1'b1);
        check("char sent", got, 8'hA5);
    endtask
    task t_stop;
        n0 = got_n;
        apb(1'b1, 12'h008, 32'h0000003C);
        apb(1'b1, 12'h008, 32'h000000C3);
        apb(1'b1, 12'h000, 32'h00000000);
        check("pin kept", txd_oe, 1'b1);
        for (int n = 0; txd_oe !== 1'b0; n++)
        begin
            if (n > 200)
            begin
                n_fail++;
                stop_test;
            end
            @(posedge clk);
        end
        check("last char", got, 8'h3C);
        check("queue dropped", got_n, n0 + 1);
        apb(1'b0, 12'h004, 32'h00000000);
        check("flags after stop", {rd[7], rd[1:0]}, 3'h3);
    endtask
    task t_rx;
        apb(1'b1, 12'h000, 32'h00000008);
        i_far.send(8'h55, 1'b0, 1'b0);
        apb(1'b0, 12'h004, 32'h00000000);
        check("rx full", rd[5:2], 4'h1);
        check("rx irq", irq, 1'b1);
        i_far.send(8'hAA, 1'b1, 1'b1);
        apb(1'b0, 12'h004, 32'h00000000);
        check("overrun", rd[5:2], 4'h3);
        apb(1'b0, 12'h00C, 32'h00000000);
        check("old char kept", rd[7:0], 8'h55);
        apb(1'b0, 12'h004, 32'h00000000);
        check("rx cleared", rd[5:2], 4'h0);
        apb(1'b1, 12'h000, 32'h00000010);
        i_far.send(8'h0F, 1'b1, 1'b1);
        apb(1'b0, 12'h004, 32'h00000000);
        check("noise framing", rd[5:2], 4'hD);
        check("no irq from them", irq, 1'b0);
        wait_stat(6);
        check("idle irq", irq, 1'b1);
        apb(1'b0, 12'h00C, 32'h00000000);
        repeat (80) @(posedge clk);
        apb(1'b0, 12'h004, 32'h00000000);
        check("idle set once", rd[6], 1'b0);
    endtask
    // Reset in mid-character must drop the pin at once
    task t_reset;
        apb(1'b1, 12'h000, 32'h00000001);
        apb(1'b1, 12'h008, 32'h0000005A);
        repeat (6) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        check("reset drops pin", {txd_oe, txd_out}, 2'h1);
        rst <= 1'b0;
        apb(1'b0, 12'h004, 32'h00000000);
        check("reset stops shifter", rd[7:0], 8'h00);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_bus;
        t_tx;
        t_stop;
        t_rx;
        t_reset;
        stop_test;
    end
endmodule // assf_status_tb
bind assf_status assf_status_properties #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .txd_out, .txd_oe, .irq);
`default_nettype wire
